// ---- scpm_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz core clock
// Notes: Included by the clock and mode controller
`ifndef SCPM_MAP_SVH
`define SCPM_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCPM_OFS_MODE 8'h00
`define SCPM_OFS_CTRL 8'h04
`define SCPM_OFS_STAT 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCPM_MODE_DIV_HI 7
`define SCPM_MODE_DIV_LO 5
`define SCPM_MODE_SLOW_RDY 3
`define SCPM_MODE_FAST_RDY 2
`define SCPM_MODE_IDLE_EN 1
`define SCPM_MODE_FSSEL 0
`define SCPM_CTRL_KEEP 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCPM_RST_DIV 3'h0
`define SCPM_RST_IDLE_EN 1'b1
`define SCPM_RST_FSSEL 1'b1
`define SCPM_RST_KEEP 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCPM_CORE_HZ 40000000
`define SCPM_FAST_HZ 20000000
`define SCPM_SLOW_HZ 32000
`define SCPM_FAST_DIV (`SCPM_CORE_HZ / `SCPM_FAST_HZ)
`define SCPM_SLOW_DIV (`SCPM_CORE_HZ / `SCPM_SLOW_HZ)
`define SCPM_FAST_STAB_NS 10000
`define SCPM_FAST_STAB_CYC ((`SCPM_FAST_STAB_NS * 40 + 999) / 1000)
`define SCPM_SLOW_STAB_US 1000
`define SCPM_SLOW_STAB_CYC (`SCPM_SLOW_STAB_US * 40)
`define SCPM_MAX_SHIFT 6

`endif

// ---- scpm_pkg.sv ----
// Purpose: Types for the clock and mode controller
// Assumes: Nothing beyond the map header
// Notes: One-hot mode codes
package scpm_pkg;

  typedef enum logic [4:0]
  {
    SCPM_NORMAL = 5'b00001,
    SCPM_SLOW = 5'b00010,
    SCPM_SLEEP = 5'b00100,
    SCPM_IDLE0 = 5'b01000,
    SCPM_IDLE1 = 5'b10000
  } scpm_mode_t;

endpackage

// ---- scpm_top.sv ----
// Purpose: System clock selection and operating mode sequencing
// Assumes: Oscillators modelled as tick enables on CORE_CLK
// Notes: Every derived clock leaves as a one-cycle enable pulse
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "scpm_map.svh"

module scpm_top
  import scpm_pkg::*;
#(
  parameter int SLOW_STAB_CYC = `SCPM_SLOW_STAB_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic HALT,
  input wire logic WAKE,
  output logic CPU_CLK_EN,
  output logic SYS_CLK_EN,
  output logic SUB_CLK_EN,
  output logic WDT_CLK_EN,
  output logic TBC_CLK_EN,
  output logic FAST_PERIPH_EN,
  output logic FAST_OSC_ON,
  output logic [4:0] MODE
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two stages so release never lands inside a setup window
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Selection decode
  // ----------------------------------------------------------------
  // Codes 000 and 001 pick slow when the select bit is low
  function automatic logic sel_is_slow(input logic fs, input logic [2:0] d);
    sel_is_slow = !fs && (d[2:1] == 2'b00);
  endfunction

  // Mask of prescaler bits that must be ones for a divided tick
  function automatic logic [5:0] sel_mask(input logic fs, input logic [2:0] d);
    logic [2:0] k;
    k = 3'(4'h8 - {1'b0, d});
    if (fs || d[2:1] == 2'b00)
      sel_mask = 6'h00;
    else
      sel_mask = 6'(6'h3F >> (3'(`SCPM_MAX_SHIFT) - k));
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] div_r;
  logic idle_en_r;
  logic fssel_r;
  logic keep_r;
  logic [3:0] act_r;
  logic [3:0] act_nxt;
  scpm_mode_t mode_r;
  scpm_mode_t mode_nxt;
  logic fast_rdy_r;
  logic slow_rdy_r;
  logic [8:0] fast_cnt_r;
  logic [15:0] slow_cnt_r;
  logic [10:0] slow_div_r;
  logic fast_ph_r;
  logic [5:0] pre_r;
  logic sw_r;

  // Ready bits have no write path: hardware alone owns them
  wire wr_mode = WR && (ADDR == `SCPM_OFS_MODE);
  wire wr_ctrl = WR && (ADDR == `SCPM_OFS_CTRL);

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= `SCPM_RST_DIV;
      idle_en_r <= `SCPM_RST_IDLE_EN;
      fssel_r <= `SCPM_RST_FSSEL;
      keep_r <= `SCPM_RST_KEEP;
    end
    else
    begin
      if (wr_mode)
      begin
        div_r <= WDATA[`SCPM_MODE_DIV_HI:`SCPM_MODE_DIV_LO];
        idle_en_r <= WDATA[`SCPM_MODE_IDLE_EN];
        fssel_r <= WDATA[`SCPM_MODE_FSSEL];
      end
      if (wr_ctrl)
        keep_r <= WDATA[`SCPM_CTRL_KEEP];
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  wire run = (mode_r == SCPM_NORMAL) || (mode_r == SCPM_SLOW);
  wire act_slow = sel_is_slow(act_r[3], act_r[2:0]);
  wire tgt_slow = sel_is_slow(fssel_r, div_r);
  // Run mode follows the active source, not the pending request
  wire run_mode_slow = act_slow;

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      SCPM_NORMAL, SCPM_SLOW:
        if (HALT && !idle_en_r)
          mode_nxt = SCPM_SLEEP;
        else if (HALT && !keep_r)
          mode_nxt = SCPM_IDLE0;
        else if (HALT)
          mode_nxt = SCPM_IDLE1;
        else
          mode_nxt = run_mode_slow ? SCPM_SLOW : SCPM_NORMAL;
      SCPM_SLEEP, SCPM_IDLE0, SCPM_IDLE1:
        if (WAKE)
          mode_nxt = run_mode_slow ? SCPM_SLOW : SCPM_NORMAL;
      default:
        mode_nxt = SCPM_NORMAL;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= SCPM_NORMAL;
    else
      mode_r <= mode_nxt;
  end

  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  // Fast stays up in run while either side of a switch needs it
  wire fast_on = (run && (!act_slow || !tgt_slow))
    || (mode_r == SCPM_IDLE1 && !act_slow);
  wire fast_tick = fast_on && fast_rdy_r && fast_ph_r;
  // Slow side never powers down: watchdog timing relies on it
  wire slow_tick = slow_rdy_r
    && (slow_div_r == 11'(`SCPM_SLOW_DIV - 1));

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_ph_r <= 1'b0;
      fast_cnt_r <= 9'h000;
      fast_rdy_r <= 1'b0;
      slow_cnt_r <= 16'h0000;
      slow_rdy_r <= 1'b0;
      slow_div_r <= 11'h000;
    end
    else
    begin
      fast_ph_r <= fast_on && !fast_ph_r;
      // Ready drops with power so a restart waits out settling
      if (!fast_on)
      begin
        fast_cnt_r <= 9'h000;
        fast_rdy_r <= 1'b0;
      end
      else if (fast_cnt_r == 9'(`SCPM_FAST_STAB_CYC - 1))
        fast_rdy_r <= 1'b1;
      else
        fast_cnt_r <= fast_cnt_r + 9'h001;
      if (slow_cnt_r == 16'(SLOW_STAB_CYC - 1))
        slow_rdy_r <= 1'b1;
      else
        slow_cnt_r <= slow_cnt_r + 16'h0001;
      if (slow_tick || !slow_rdy_r)
        slow_div_r <= 11'h000;
      else
        slow_div_r <= slow_div_r + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // System clock selection
  // ----------------------------------------------------------------
  logic [5:0] act_mask;
  assign act_mask = sel_mask(act_r[3], act_r[2:0]);
  wire div_tick = fast_tick && ((pre_r & act_mask) == act_mask);
  wire sys_src = act_slow ? slow_tick : div_tick;
  // Blank the cycle after a switch: old and new ticks never abut
  wire sys_raw = sys_src && !sw_r;
  wire tgt_ok = tgt_slow ? slow_rdy_r : fast_rdy_r;
  wire sys_on = run || (mode_r == SCPM_IDLE1);

  // Switch only on a tick of the old source: no runt period
  assign act_nxt = (run && sys_raw && tgt_ok) ? {fssel_r, div_r} : act_r;

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_r <= {`SCPM_RST_FSSEL, `SCPM_RST_DIV};
      pre_r <= 6'h00;
      sw_r <= 1'b0;
    end
    else
    begin
      act_r <= act_nxt;
      sw_r <= (act_nxt != act_r);
      if (!fast_on)
        pre_r <= 6'h00;
      else if (fast_tick)
        pre_r <= pre_r + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Clock enable outputs
  // ----------------------------------------------------------------
  // Registered so each enable is one clean cycle wide
  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CPU_CLK_EN <= 1'b0;
      SYS_CLK_EN <= 1'b0;
      SUB_CLK_EN <= 1'b0;
      WDT_CLK_EN <= 1'b0;
      TBC_CLK_EN <= 1'b0;
      FAST_PERIPH_EN <= 1'b0;
      FAST_OSC_ON <= 1'b0;
      MODE <= 5'h01;
    end
    else
    begin
      CPU_CLK_EN <= sys_raw && run;
      SYS_CLK_EN <= sys_raw && sys_on;
      SUB_CLK_EN <= slow_tick;
      WDT_CLK_EN <= slow_tick;
      TBC_CLK_EN <= slow_tick && (mode_r != SCPM_SLEEP);
      FAST_PERIPH_EN <= fast_tick;
      FAST_OSC_ON <= fast_on;
      MODE <= mode_r;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Zero outside the answer cycle keeps a stray sample harmless
  logic [7:0] rd_val;
  wire [7:0] mode_val = {div_r, 1'b0, slow_rdy_r, fast_rdy_r, idle_en_r,
    fssel_r};

  always_comb
  begin
    if (ADDR == `SCPM_OFS_MODE)
      rd_val = mode_val;
    else if (ADDR == `SCPM_OFS_CTRL)
      rd_val = {keep_r, 7'h00};
    else if (ADDR == `SCPM_OFS_STAT)
      rd_val = {3'h0, mode_r};
    else
      rd_val = 8'h00;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
      RDATA <= 8'h00;
    else
      RDATA <= RD ? rd_val : 8'h00;
  end

endmodule

// ---- scpm_top_properties.sv ----
// Purpose: Port-level checks of clock enables and modes
// Assumes: Pulses and MODE are registers on CORE_CLK
// Notes: Halt checks wait one cycle for the pulse lag
`timescale 1ns/1ps
module scpm_chk
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CPU_CLK_EN,
  input wire logic SYS_CLK_EN,
  input wire logic SUB_CLK_EN,
  input wire logic WDT_CLK_EN,
  input wire logic TBC_CLK_EN,
  input wire logic FAST_PERIPH_EN,
  input wire logic FAST_OSC_ON,
  input wire logic [4:0] MODE
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  wire halted = |MODE[4:2];
  wire dark = MODE[2] | MODE[3];
  chk_mode_onehot: assert property ($onehot(MODE))
    else $error("mode not one-hot");
  chk_cpu_halted: assert property
    (halted && $past(halted) |-> !CPU_CLK_EN)
    else $error("cpu clock in halt mode");
  chk_sys_dark: assert property
    (dark && $past(dark) |-> !SYS_CLK_EN)
    else $error("system clock in sleep or idle0");
  chk_tbc_sleep: assert property
    (MODE[2] && $past(MODE[2]) |-> !TBC_CLK_EN)
    else $error("timebase clock in sleep");
  chk_wdt_sub: assert property (WDT_CLK_EN == SUB_CLK_EN)
    else $error("watchdog clock differs from substitute");
  chk_tbc_slow: assert property (TBC_CLK_EN |-> SUB_CLK_EN)
    else $error("timebase clock not a slow tick");
  chk_fast_off: assert property
    (!FAST_OSC_ON && $past(!FAST_OSC_ON) |-> !FAST_PERIPH_EN)
    else $error("fast tick with oscillator off");
  chk_fast_rate: assert property
    (FAST_PERIPH_EN |=> !FAST_PERIPH_EN)
    else $error("fast tick too frequent");
  chk_sub_rate: assert property
    (SUB_CLK_EN |=> !SUB_CLK_EN [*8])
    else $error("slow tick too frequent");
  chk_cpu_sys: assert property (CPU_CLK_EN |-> SYS_CLK_EN)
    else $error("cpu clock without system clock");
  chk_sys_runt: assert property
    (SYS_CLK_EN |=> !SYS_CLK_EN)
    else $error("system clock pulses too close");
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  cov_slow: cover property (MODE[1]);
  cov_sleep: cover property (MODE[2]);
  cov_idle0: cover property (MODE[3]);
  cov_idle1: cover property (MODE[4]);
endmodule

bind scpm_top scpm_chk u_chk (.CORE_CLK, .ARST_N, .RD, .RDATA,
  .CPU_CLK_EN, .SYS_CLK_EN, .SUB_CLK_EN, .WDT_CLK_EN, .TBC_CLK_EN,
  .FAST_PERIPH_EN, .FAST_OSC_ON, .MODE);

// ---- system_clock_and_power_modes_bench.sv ----
// Purpose: Self-checking bench for the clock and mode controller
// Assumes: Short slow settle time for simulation
// Notes: Periods measured between system clock pulses
`timescale 1ns/1ps
module system_clock_and_power_modes_bench;
  import scpm_pkg::*;
  logic CORE_CLK = 0, ARST_N = 0, WR = 0, RD = 0, HALT = 0, WAKE = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
  logic CPU_CLK_EN, SYS_CLK_EN, SUB_CLK_EN, WDT_CLK_EN, TBC_CLK_EN;
  logic FAST_PERIPH_EN, FAST_OSC_ON;
  logic [4:0] MODE;
  logic [2:0] c;
  int bad_count = 0, checks = 0, seed = 95, p, k, nc, ns, nt, nu;
  scpm_mode_t md [3] = '{SCPM_SLEEP, SCPM_IDLE0, SCPM_IDLE1};
  scpm_top #(.SLOW_STAB_CYC(20)) DUT (.CORE_CLK, .ARST_N, .ADDR,
    .WDATA, .WR, .RD, .RDATA, .HALT, .WAKE, .CPU_CLK_EN, .SYS_CLK_EN,
    .SUB_CLK_EN, .WDT_CLK_EN, .TBC_CLK_EN, .FAST_PERIPH_EN,
    .FAST_OSC_ON, .MODE);
  // ------------------------------------------------------------
  // Clock, counters and tasks
  // ------------------------------------------------------------
  initial forever #12.5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    nc += CPU_CLK_EN;
    ns += SYS_CLK_EN;
    nt += TBC_CLK_EN;
    nu += SUB_CLK_EN;
  end
  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1;
    @(posedge CORE_CLK);
    WR <= 0;
  endtask
  task rd(logic [7:0] a, output logic [7:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge CORE_CLK);
    RD <= 0;
    #1 v = RDATA;
  endtask
  // Waits are bounded so a dead clock cannot hang the run
  task per(output int q);
    int i;
    for (i = 0; i < 3000 && !SYS_CLK_EN; i++) @(posedge CORE_CLK);
    @(posedge CORE_CLK);
    for (q = 1; q < 3000 && !SYS_CLK_EN; q++) @(posedge CORE_CLK);
  endtask
  task count(int n);
    @(negedge CORE_CLK);
    nc = 0;
    ns = 0;
    nt = 0;
    nu = 0;
    repeat (n) @(posedge CORE_CLK);
  endtask
  // Fast tick every two core cycles, then the divider ratio
  function automatic int exp_per(logic fs, logic [2:0] cd);
    if (fs)
      exp_per = 2;
    else if (cd[2:1] == 2'b00)
      exp_per = 1250;
    else
      exp_per = 2 << (8 - cd);
  endfunction
  task close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    bad_count++;
    close_out;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1;
    repeat (3) @(posedge CORE_CLK);
    rd(8'h00, d);
    chk("mode_reg", d, 16'h03);
    rd(8'h04, d);
    chk("ctrl_reg", d, 16'h00);
    rd(8'h08, d);
    chk("status", d, 16'h01);
    repeat (450) @(posedge CORE_CLK);
    wr(8'h00, 8'hFF);
    rd(8'h00, d);
    chk("ready_ro", d, 16'hEF);
    wr(8'h3C, 8'($random(seed)));
    rd(8'h3C, d);
    chk("unmapped", d, 16'h00);
    for (k = 0; k < 3; k++)
    begin
      wr(8'h00, {6'h00, k > 0, 1'b1});
      wr(8'h04, {k == 2, 7'h00});
      @(posedge CORE_CLK);
      HALT <= 1;
      @(posedge CORE_CLK);
      HALT <= 0;
      repeat (3) @(posedge CORE_CLK);
      #1 chk("halt_mode", 16'(MODE), 16'(md[k]));
      count(1300);
      chk("cpu", {15'h0, nc > 0}, 16'h0);
      chk("sys", {15'h0, ns > 0}, {15'h0, k == 2});
      chk("tbc", {15'h0, nt > 0}, {15'h0, k > 0});
      chk("sub", {15'h0, nu > 0}, 16'h1);
      @(posedge CORE_CLK);
      WAKE <= 1;
      @(posedge CORE_CLK);
      WAKE <= 0;
      repeat (3) @(posedge CORE_CLK);
      #1 chk("wake", 16'(MODE), 16'(SCPM_NORMAL));
    end
    per(p);
    per(p);
    chk("undiv", 16'(p), 16'(exp_per(1'b1, 3'h0)));
    for (k = 0; k < 8; k++)
    begin
      c = k == 0 ? 3'h2 : k == 1 ? 3'h7 : 3'(2 + {$random(seed)} % 6);
      wr(8'h00, {c, 5'h02});
      // Third interval: the first two may straddle the switch
      per(p);
      per(p);
      per(p);
      chk("divided", 16'(p), 16'(exp_per(1'b0, c)));
    end
    wr(8'h00, 8'h02);
    per(p);
    per(p);
    per(p);
    chk("slow", 16'(p), 16'(exp_per(1'b0, 3'h0)));
    repeat (5) @(posedge CORE_CLK);
    #1 chk("fast_on", {15'h0, FAST_OSC_ON}, 16'h0);
    rd(8'h08, d);
    chk("status", d, 16'h02);
    close_out;
  end
endmodule
